// *** hall_speed_direction_core.sv ***
// Purpose: start-up, calibration, hysteresis switching, direction and supply handling
// Assumes: inputs synchronous to clk; supply flags come from an analog supervisor
// Notes: pulse widths of the current protocol live in the downstream encoder
module hall_speed_direction_core
  import hall_core_pkg::*;
#(
  parameter int W = SAMPLE_W,
  parameter int OW = OFFSET_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Digitized inputs
  input wire logic sample_valid,
  input wire logic signed [W-1:0] speed,
  input wire logic signed [W-1:0] outer_element_a,
  input wire logic signed [W-1:0] outer_element_b,
  input wire logic signed [W-1:0] center_element,
  input wire logic [W-1:0] amp_limit,
  // Supply supervisor
  input wire logic undervoltage,
  input wire logic below_reset,
  // Offset correction converter
  output logic signed [OW-1:0] offset_dac,
  // Pulse requests to the protocol encoder
  output logic pulse_req,
  output logic pulse_has_dir,
  output logic pulse_dir,
  output logic force_high,
  // Status
  output logic calibrated,
  output logic [W-1:0] noise_threshold
);
  typedef struct packed {
    mode_t mode;
    logic [2:0] pulse_count;
    logic out_high;
    logic signed [W-1:0] prev_speed;
    logic signed [W-1:0] peak;
    logic signed [OW-1:0] offset;
    logic [1:0] upd_extrema;
    logic uv_armed;
    logic force_high;
    logic pulse_req;
    logic pulse_has_dir;
    logic pulse_dir;
    logic [W-1:0] noise_threshold;
  } core_t;
  core_t s, next_s;

  logic clear;
  logic signed [W-1:0] max_val, min_val;
  logic [W-1:0] amplitude;
  logic [1:0] extrema_count;
  logic dir_valid, dir_value, dir_weak;
  logic zero_cross;
  logic [W-1:0] hyst, floor2, thr;
  logic signed [W:0] mid, thr_s;
  logic rise_ev, fall_ev, switch_ev, small_sig, vib;

  // Whole core restarts while supply is below the reset level
  assign clear = below_reset;
  assign zero_cross = (speed[W-1] != s.prev_speed[W-1]);

  amplitude_tracker #(.W(W)) u_trk (
    .clk(clk),
    .nrst(nrst),
    .clear(clear),
    .sample_valid(sample_valid),
    .speed(speed),
    .amp_limit(amp_limit),
    .max_val(max_val),
    .min_val(min_val),
    .amplitude(amplitude),
    .extrema_count(extrema_count)
  );

  direction_sampler #(.W(W)) u_dir (
    .clk(clk),
    .nrst(nrst),
    .clear(clear),
    .sample_valid(sample_valid),
    .outer_element_a(outer_element_a),
    .outer_element_b(outer_element_b),
    .center_element(center_element),
    .zero_cross(zero_cross),
    .amp_limit(amp_limit),
    .dir_valid(dir_valid),
    .dir_value(dir_value),
    .dir_weak(dir_weak)
  );

  function automatic logic [W-1:0] max_u(input logic [W-1:0] a, input logic [W-1:0] b);
    max_u = (a > b) ? a : b;
  endfunction

  always_comb begin
    floor2 = amp_limit << 1;
    hyst = max_u(amplitude >> HYST_SHIFT, amp_limit);
    small_sig = amplitude < floor2;
    thr = (s.mode == ST_CAL) ? hyst : s.noise_threshold;
    // Signed view so a negative excursion never reads as a huge one
    thr_s = $signed({1'b0, thr});
    mid = ((W+1)'(max_val) + (W+1)'(min_val)) >>> 1;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    vib = 1'b0;
    next_s = s;
    next_s.pulse_req = 1'b0;
    // Undervoltage forces high current level, only once armed
    next_s.force_high = s.uv_armed && undervoltage;
    if (sample_valid) begin
      next_s.prev_speed = speed;
      // Excursions inside the threshold band never switch
      if (!s.out_high && ((W+1)'(speed) - (W+1)'(s.peak)) > thr_s) rise_ev = 1'b1;
      if (s.out_high && ((W+1)'(s.peak) - (W+1)'(speed)) > thr_s) fall_ev = 1'b1;
      if (rise_ev || fall_ev) begin
        next_s.out_high = rise_ev;
        next_s.peak = speed;
      end else if (s.out_high ? (speed > s.peak) : (speed < s.peak)) begin
        next_s.peak = speed;
      end
      // Noise threshold tracking per mode
      if (s.mode == ST_CAL) begin
        next_s.noise_threshold = max_u(amplitude >> THR_SHIFT_CAL, floor2);
      end else begin
        next_s.noise_threshold = max_u(amplitude, floor2);
      end
      // Offset moves only with the current edge, independent of pulses
      if (extrema_count >= 2'h2) begin
        if (mid > 0 && s.out_high) begin
          next_s.offset = s.offset + OW'(1);
        end else if (mid < 0 && !s.out_high) begin
          next_s.offset = s.offset - OW'(1);
        end else if (mid == 0) begin
          next_s.mode = ST_CAL;
        end
      end
    end
    switch_ev = rise_ev;
    // Direction based vibration check only after calibration
    if (s.mode == ST_CAL && dir_valid && dir_weak) vib = 1'b1;
    case (s.mode)
      ST_WAIT_RISE: begin
        if (switch_ev) begin
          // First pulse is always speed only
          next_s.pulse_req = 1'b1;
          next_s.pulse_has_dir = 1'b0;
          next_s.pulse_count = 3'h1;
          next_s.mode = ST_UNCAL;
          next_s.uv_armed = 1'b1;
        end
      end
      ST_UNCAL: begin
        if (switch_ev) begin
          if (s.pulse_count != 3'h7) next_s.pulse_count = s.pulse_count + 3'h1;
          // Third pulse may drop on small signals
          if (!(small_sig && s.pulse_count == 3'(STARTUP_PULSES))) begin
            next_s.pulse_req = 1'b1;
            next_s.pulse_has_dir = 1'b0;
          end
        end
      end
      ST_CAL: begin
        if (switch_ev && !vib) begin
          next_s.pulse_req = 1'b1;
          next_s.pulse_has_dir = dir_valid;
          next_s.pulse_dir = dir_value;
        end
      end
      default: next_s.mode = ST_WAIT_RISE;
    endcase
    if (clear) begin
      next_s = '0;
      next_s.mode = ST_WAIT_RISE;
      next_s.noise_threshold = floor2;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.mode <= ST_WAIT_RISE;
      s.noise_threshold <= {AMP_LIMIT_DEFAULT[W-2:0], 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign offset_dac = s.offset;
  assign pulse_req = s.pulse_req;
  assign pulse_has_dir = s.pulse_has_dir;
  assign pulse_dir = s.pulse_dir;
  assign force_high = s.force_high;
  assign calibrated = (s.mode == ST_CAL);
  assign noise_threshold = s.noise_threshold;
endmodule

// *** hall_core_pkg.sv ***
// Purpose: constants and types shared by the speed/direction core
// Assumes: signed digitized speed and direction samples, one 50 MHz clock
// Notes: amplitudes are in ADC counts
package hall_core_pkg;
  localparam int SAMPLE_W = 12;
  localparam int OFFSET_W = 10;
  localparam logic [SAMPLE_W-1:0] AMP_LIMIT_DEFAULT = 12'h010;
  localparam int THR_SHIFT_CAL = 1;
  localparam int HYST_SHIFT = 3;
  localparam int STARTUP_PULSES = 2;
  localparam int CAL_PULSE_NUM = 4;
  localparam int DIR_FORWARD = 1;
  typedef enum {ST_WAIT_RISE, ST_UNCAL, ST_CAL} mode_t;
endpackage

// *** amplitude_tracker.sv ***
// Purpose: track extrema of the speed signal and derive amplitude
// Assumes: sample_valid marks new speed samples
// Notes: extrema are latched at slope reversal beyond the limit
module amplitude_tracker
  import hall_core_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  // Samples
  input wire logic sample_valid,
  input wire logic signed [W-1:0] speed,
  input wire logic [W-1:0] amp_limit,
  // Results
  output logic signed [W-1:0] max_val,
  output logic signed [W-1:0] min_val,
  output logic [W-1:0] amplitude,
  output logic [1:0] extrema_count
);
  typedef struct packed {
    logic signed [W-1:0] run_max;
    logic signed [W-1:0] run_min;
    logic signed [W-1:0] max_val;
    logic signed [W-1:0] min_val;
    logic [W-1:0] amplitude;
    logic [1:0] extrema_count;
    logic rising;
  } trk_t;
  trk_t s, next_s;
  logic signed [W:0] span;

  always_comb begin
    next_s = s;
    span = '0;
    if (clear) begin
      next_s = '0;
    end else if (sample_valid) begin
      if (s.rising) begin
        if (speed > s.run_max) begin
          next_s.run_max = speed;
        end else if ((W+1)'(s.run_max) - (W+1)'(speed) > (W+1)'(amp_limit)) begin
          next_s.max_val = s.run_max;
          next_s.rising = 1'b0;
          next_s.run_min = speed;
          if (s.extrema_count != 2'h3) next_s.extrema_count = s.extrema_count + 2'h1;
        end
      end else begin
        if (speed < s.run_min) begin
          next_s.run_min = speed;
        end else if ((W+1)'(speed) - (W+1)'(s.run_min) > (W+1)'(amp_limit)) begin
          next_s.min_val = s.run_min;
          next_s.rising = 1'b1;
          next_s.run_max = speed;
          if (s.extrema_count != 2'h3) next_s.extrema_count = s.extrema_count + 2'h1;
        end
      end
      span = (W+1)'(next_s.max_val) - (W+1)'(next_s.min_val);
      next_s.amplitude = span[W] ? '0 : span[W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s <= '0;
    else s <= next_s;
  end

  assign max_val = s.max_val;
  assign min_val = s.min_val;
  assign amplitude = s.amplitude;
  assign extrema_count = s.extrema_count;
endmodule

// *** direction_sampler.sv ***
// Purpose: derive the direction signal and sample it at speed zero crossings
// Assumes: outer and center element samples are offset free and signed
// Notes: lead or lag of the center probe gives the sign at the crossing
module direction_sampler
  import hall_core_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  // Samples
  input wire logic sample_valid,
  input wire logic signed [W-1:0] outer_element_a,
  input wire logic signed [W-1:0] outer_element_b,
  input wire logic signed [W-1:0] center_element,
  input wire logic zero_cross,
  input wire logic [W-1:0] amp_limit,
  // Results
  output logic dir_valid,
  output logic dir_value,
  output logic dir_weak
);
  typedef struct packed {
    logic dir_valid;
    logic dir_value;
    logic dir_weak;
  } dir_t;
  dir_t s, next_s;
  logic signed [W+1:0] diff;
  logic [W+1:0] mag;

  always_comb begin
    next_s = s;
    // Center minus mean of outer elements, mean kept exact by doubling
    diff = ((W+2)'(center_element) <<< 1) - (W+2)'(outer_element_a)
      - (W+2)'(outer_element_b);
    mag = diff[W+1] ? (W+2)'(-diff) : diff;
    if (clear) begin
      next_s = '0;
    end else if (sample_valid && zero_cross) begin
      next_s.dir_valid = 1'b1;
      next_s.dir_value = ~diff[W+1];
      next_s.dir_weak = mag < ((W+2)'(amp_limit) <<< 1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s <= '0;
    else s <= next_s;
  end

  assign dir_valid = s.dir_valid;
  assign dir_value = s.dir_value;
  assign dir_weak = s.dir_weak;
endmodule

// *** hall_core_properties.sv ***
// Purpose: port-level checks of the speed/direction core
// Assumes: amp_limit held steady while out of reset
// Notes: seen marks that a pulse went out since the last clear
module hall_core_properties
  import hall_core_pkg::*;
#(
  parameter int W = SAMPLE_W,
  parameter int OW = OFFSET_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Inputs
  input wire logic sample_valid,
  input wire logic [W-1:0] amp_limit,
  input wire logic undervoltage,
  input wire logic below_reset,
  // Outputs
  input wire logic signed [OW-1:0] offset_dac,
  input wire logic pulse_req,
  input wire logic pulse_has_dir,
  input wire logic force_high,
  input wire logic calibrated,
  input wire logic [W-1:0] noise_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) seen <= 1'b0;
    else if (below_reset) seen <= 1'b0;
    else if (pulse_req) seen <= 1'b1;
  end
  property p_pulse_short;
    pulse_req |=> !pulse_req;
  endproperty
  a_pulse_short: assert property (p_pulse_short) else $error("pulse longer than one cycle");
  property p_pulse_cause;
    pulse_req |-> $past(sample_valid);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without a sample");
  property p_first_plain;
    pulse_req && !seen |-> !pulse_has_dir;
  endproperty
  a_first_plain: assert property (p_first_plain) else $error("first pulse has direction");
  property p_dir_cal;
    pulse_req && pulse_has_dir |-> calibrated;
  endproperty
  a_dir_cal: assert property (p_dir_cal) else $error("direction while uncalibrated");
  property p_thr_floor;
    {1'b0, noise_threshold} >= {amp_limit, 1'b0};
  endproperty
  a_thr_floor: assert property (p_thr_floor) else $error("threshold under floor");
  property p_uv_arm;
    $rose(force_high) |-> seen;
  endproperty
  a_uv_arm: assert property (p_uv_arm) else $error("undervoltage before arming");
  property p_uv_on;
    undervoltage && seen && !below_reset |=> force_high;
  endproperty
  a_uv_on: assert property (p_uv_on) else $error("high current not forced");
  property p_uv_off;
    !undervoltage |=> !force_high;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("high current not released");
  property p_clear;
    below_reset |=> !calibrated && !force_high && !pulse_req
      && noise_threshold == {amp_limit[W-2:0], 1'b0};
  endproperty
  a_clear: assert property (p_clear) else $error("supply reset not applied");
  property p_offset_step;
    !$past(below_reset) && offset_dac != $past(offset_dac) |->
      offset_dac == $past(offset_dac) + OW'(1) || offset_dac == $past(offset_dac) - OW'(1);
  endproperty
  a_offset_step: assert property (p_offset_step) else $error("offset step not one");
endmodule

bind hall_speed_direction_core hall_core_properties #(.W(W), .OW(OW)) u_props (
  .clk(clk), .nrst(nrst), .sample_valid(sample_valid), .amp_limit(amp_limit),
  .undervoltage(undervoltage), .below_reset(below_reset), .offset_dac(offset_dac),
  .pulse_req(pulse_req), .pulse_has_dir(pulse_has_dir), .force_high(force_high),
  .calibrated(calibrated), .noise_threshold(noise_threshold)
);

// *** tcu_model.sv ***
// Purpose: receiving control unit, counts pulse requests
// Assumes: requests last one cycle
// Notes: keeps only the latest tag, enough for per-period checks
module tcu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pulse requests
  input wire logic pulse_req,
  input wire logic pulse_has_dir,
  input wire logic pulse_dir,
  // Decoded view
  output logic [7:0] n_pulses,
  output logic last_has_dir,
  output logic last_dir
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_pulses <= 8'h00;
      last_has_dir <= 1'b0;
      last_dir <= 1'b0;
    end else if (pulse_req) begin
      n_pulses <= n_pulses + 8'h01;
      last_has_dir <= pulse_has_dir;
      last_dir <= pulse_dir;
    end
  end
endmodule

// *** hall_speed_direction_core_tb.sv ***
// Purpose: scenario bench for the speed/direction core
// Assumes: triangle speed wave, center sign sets direction
// Notes: outer elements held at zero to keep the direction term pure
module hall_speed_direction_core_tb
  import hall_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, sample_valid, undervoltage, below_reset;
  logic signed [11:0] speed, outer_element_a, outer_element_b, center_element;
  logic [11:0] amp_limit, noise_threshold;
  logic signed [9:0] offset_dac;
  logic pulse_req, pulse_has_dir, pulse_dir, force_high, calibrated;
  logic [7:0] n_pulses;
  logic last_has_dir, last_dir;
  int error_cnt = 0;
  int n_compared = 0;
  hall_speed_direction_core u_hall_speed_direction_core (
    .clk(clk), .nrst(nrst), .sample_valid(sample_valid), .speed(speed),
    .outer_element_a(outer_element_a), .outer_element_b(outer_element_b),
    .center_element(center_element), .amp_limit(amp_limit),
    .undervoltage(undervoltage), .below_reset(below_reset), .offset_dac(offset_dac),
    .pulse_req(pulse_req), .pulse_has_dir(pulse_has_dir), .pulse_dir(pulse_dir),
    .force_high(force_high), .calibrated(calibrated), .noise_threshold(noise_threshold)
  );
  tcu_model u_tcu_model (
    .clk(clk), .nrst(nrst), .pulse_req(pulse_req), .pulse_has_dir(pulse_has_dir),
    .pulse_dir(pulse_dir), .n_pulses(n_pulses), .last_has_dir(last_has_dir),
    .last_dir(last_dir)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic smp(input logic signed [11:0] s);
    @(posedge clk);
    speed <= s;
    sample_valid <= 1'b1;
  endtask
  // One magnetic period: rise from -a to +a, fall back, then settle
  task automatic period(input int a, input int c);
    center_element <= 12'(c);
    for (int i = -4; i < 4; i++) smp(12'(i * a / 4));
    for (int i = 4; i > -4; i--) smp(12'(i * a / 4));
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic s_start();
    chk("thr_reset", 12'h020, noise_threshold);
    undervoltage <= 1'b1;
    repeat (4) @(posedge clk);
    chk("force_unarmed", 12'h000, 12'(force_high));
    undervoltage <= 1'b0;
    period(256, 256);
    chk("first_count", 12'h001, 12'(n_pulses));
    chk("first_plain", 12'h000, 12'(last_has_dir));
    period(256, 256);
    chk("second_count", 12'h002, 12'(n_pulses));
  endtask
  task automatic s_cal();
    for (int k = 0; k < 8 && calibrated !== 1'b1; k++) period(256, 256);
    chk("calibrated", 12'h001, 12'(calibrated));
    chk("thr_half", 12'h100, noise_threshold);
    chk("offset", 12'h000, 12'(offset_dac));
  endtask
  task automatic s_dir();
    period(256, 256);
    chk("has_dir", 12'h001, 12'(last_has_dir));
    chk("dir_fwd", 12'(DIR_FORWARD), 12'(last_dir));
    // Pulse carries the sign seen at the previous crossing, so reverse twice
    period(256, -256);
    period(256, -256);
    chk("dir_rev", 12'(1 - DIR_FORWARD), 12'(last_dir));
  endtask
  task automatic s_vib();
    logic [7:0] n0;
    // Step from the last large trough into the small band may switch once
    period(4, 256);
    n0 = n_pulses;
    repeat (4) period(4, 256);
    chk("small_swing", 12'(n0), 12'(n_pulses));
    // First weak period only records the weak crossing
    period(256, 0);
    n0 = n_pulses;
    period(256, 0);
    chk("weak_dir", 12'(n0), 12'(n_pulses));
  endtask
  task automatic s_supply();
    undervoltage <= 1'b1;
    repeat (2) @(posedge clk);
    chk("force_on", 12'h001, 12'(force_high));
    repeat (6) @(posedge clk);
    chk("force_hold", 12'h001, 12'(force_high));
    undervoltage <= 1'b0;
    repeat (2) @(posedge clk);
    chk("force_off", 12'h000, 12'(force_high));
    below_reset <= 1'b1;
    repeat (2) @(posedge clk);
    below_reset <= 1'b0;
    @(posedge clk);
    chk("uncal_again", 12'h000, 12'(calibrated));
    chk("thr_again", 12'h020, noise_threshold);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    sample_valid = 1'b0;
    speed = 12'sh000;
    outer_element_a = 12'sh000;
    outer_element_b = 12'sh000;
    center_element = 12'sh000;
    amp_limit = AMP_LIMIT_DEFAULT;
    undervoltage = 1'b0;
    below_reset = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    s_start();
    s_cal();
    s_dir();
    s_vib();
    s_supply();
    close_out();
  end
endmodule
